// [design/jlh_host_port.sv]
// Host port of the J1850 link: vector, data buffer, low-power control
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns

// Summary of operation
// - Vector shows highest pending source, steps of four
// - Vector read clears source, except data-register sources
// - Receive sources clear on vector then data read
// - Transmit empty clears on vector+write or end-of-data
// - Vector value is index times four
// - Lower pending source shows after higher clears
// - Data read returns last received byte
// - Shift done loads shadow byte into shifter
// - First bit sent sets transmit empty unless end-of-data set
// - Completed byte goes to shadow, sets receive full
// - Underrun stops transmitter after byte plus two ones
// - Aborted frame reported as invalid symbol
// - Wait instruction without wcm enters wait, no drive
// - Good message in wait wakes, interrupts if enabled
// - Stop instruction, or wait with wcm, enters stop
// - Bus going active in stop wakes, raises nmi
// - Wait-entered stop trusts byte only after end of frame
// - Stop during reception wakes on first edge, restarts clocks
module jlh_host_port #(
   parameter int STAB_CYCLES = jlh_pkg::STAB_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Frame engine
   input wire jlh_pkg::jlh_link_evt_t link_evt,
   input wire logic rx_busy,
   input wire logic bus_active,
   output jlh_pkg::jlh_tx_ctl_t tx_ctl,
   // CPU side
   output logic irq,
   output logic nmi_req,
   output logic clk_run,
   output logic rx_trust
);
   localparam int NS = jlh_pkg::NUM_SRC;
   localparam int SW = $clog2(STAB_CYCLES + 1);

   logic [NS:1] pend_r;
   logic [NS:1] pend_nxt;
   logic [NS:1] pend_set;
   logic [NS:1] pend_clr;
   logic [3:0] armed_r;
   logic [7:0] tx_shadow_r;
   logic tx_full_r;
   logic [7:0] rx_shadow_r;
   logic ie_r;
   logic wcm_r;
   logic transmit_end_of_data_r;
   logic eof_seen_r;
   logic stop_by_wait_r;
   logic stop_in_rx_r;
   logic bus_q_r;
   logic [SW-1:0] stab_r;
   jlh_pkg::jlh_mode_t mode_r;
   logic wr_go;
   logic rd_go;
   logic [7:0] wa;
   logic [7:0] ra;
   logic [3:0] vec_src;
   logic vec_rd;
   logic data_rd;
   logic data_wr;
   logic transmit_end_of_data_wr;
   logic wait_cmd;
   logic stop_cmd;
   logic msg_ok;
   logic rise;
   logic edge_seen;

   // Highest set source index
   function automatic logic [3:0] top_src(input logic [NS:1] p);
      logic [3:0] s;
      s = jlh_pkg::SRC_NONE;
      for (int i = 1; i <= NS; i++) begin
         if (p[i]) begin
            s = 4'(i);
         end
      end
      return s;
   endfunction

   function automatic logic needs_data(input logic [3:0] s);
      return s == jlh_pkg::SRC_RX_IFR || s == jlh_pkg::SRC_RX_FULL ||
         s == jlh_pkg::SRC_TX_EMPTY;
   endfunction

   // Bus handshakes
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
      !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign wa = {s_axi_awaddr[7:2], 2'h0};
   assign ra = {s_axi_araddr[7:2], 2'h0};
   assign vec_src = top_src(pend_r);
   assign vec_rd = rd_go && ra == jlh_pkg::ADDR_VECTOR;
   assign data_rd = rd_go && ra == jlh_pkg::ADDR_DATA;
   assign data_wr = wr_go && wa == jlh_pkg::ADDR_DATA &&
      s_axi_wstrb[0];
   assign transmit_end_of_data_wr = wr_go && wa == jlh_pkg::ADDR_CTRL2 &&
      s_axi_wstrb[0] && s_axi_wdata[jlh_pkg::CTRL2_TRANSMIT_END_OF_DATA_BIT];
   assign wait_cmd = wr_go && wa == jlh_pkg::ADDR_POWER &&
      s_axi_wstrb[0] && s_axi_wdata[jlh_pkg::POWER_WAIT_BIT];
   assign stop_cmd = wr_go && wa == jlh_pkg::ADDR_POWER &&
      s_axi_wstrb[0] && s_axi_wdata[jlh_pkg::POWER_STOP_BIT];
   assign msg_ok = link_evt.eof && !link_evt.crc_err &&
      !link_evt.bad_sym;
   assign rise = bus_active && !bus_q_r;
   assign edge_seen = bus_active != bus_q_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= jlh_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa == jlh_pkg::ADDR_DATA ||
               wa == jlh_pkg::ADDR_CTRL1 || wa == jlh_pkg::ADDR_CTRL2 ||
               wa == jlh_pkg::ADDR_POWER) ? jlh_pkg::RESP_OKAY :
               jlh_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= jlh_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= jlh_pkg::RESP_OKAY;
            unique case (ra)
               jlh_pkg::ADDR_VECTOR:
                  s_axi_rdata <= {26'h0, vec_src, 2'h0};
               jlh_pkg::ADDR_DATA:
                  s_axi_rdata <= {24'h0, rx_shadow_r};
               jlh_pkg::ADDR_CTRL1:
                  s_axi_rdata <= {30'h0, wcm_r, ie_r};
               jlh_pkg::ADDR_CTRL2:
                  s_axi_rdata <= {31'h0, transmit_end_of_data_r};
               jlh_pkg::ADDR_POWER:
                  s_axi_rdata <= 32'h0000_0000;
               jlh_pkg::ADDR_STATUS:
                  s_axi_rdata <= {26'h0, eof_seen_r, tx_full_r,
                     mode_r, pend_r[jlh_pkg::SRC_RX_FULL],
                     pend_r[jlh_pkg::SRC_TX_EMPTY]};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= jlh_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Control bits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {wcm_r, ie_r} <= jlh_pkg::CTRL1_RESET;
      end else if (wr_go && wa == jlh_pkg::ADDR_CTRL1 &&
            s_axi_wstrb[0]) begin
         ie_r <= s_axi_wdata[jlh_pkg::CTRL1_IE_BIT];
         wcm_r <= s_axi_wdata[jlh_pkg::CTRL1_WCM_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         transmit_end_of_data_r <= 1'b0;
      end else if (transmit_end_of_data_wr) begin
         transmit_end_of_data_r <= 1'b1;
      end else if (link_evt.eof || link_evt.arb_loss) begin
         transmit_end_of_data_r <= 1'b0;
      end
   end

   // Source flags; hardware set wins over software clear
   always_comb begin
      pend_set = '0;
      pend_clr = '0;
      pend_set[jlh_pkg::SRC_EOF] = link_evt.eof;
      pend_set[jlh_pkg::SRC_RX_IFR] = link_evt.rx_ifr;
      pend_set[jlh_pkg::SRC_RX_FULL] = link_evt.rx_byte;
      pend_set[jlh_pkg::SRC_TX_EMPTY] = link_evt.tx_first_bit &&
         !transmit_end_of_data_r;
      pend_set[jlh_pkg::SRC_ARB_LOSS] = link_evt.arb_loss;
      pend_set[jlh_pkg::SRC_CRC] = link_evt.crc_err;
      pend_set[jlh_pkg::SRC_BAD_SYM] = link_evt.bad_sym;
      pend_set[jlh_pkg::SRC_WAKE] = (mode_r == jlh_pkg::JLH_WAIT &&
         msg_ok) || (mode_r == jlh_pkg::JLH_STOP &&
         (rise || (stop_in_rx_r && edge_seen)));
      if (vec_rd && !needs_data(vec_src)) begin
         pend_clr[vec_src] = 1'b1;
      end
      if (data_rd && (armed_r == jlh_pkg::SRC_RX_FULL ||
            armed_r == jlh_pkg::SRC_RX_IFR)) begin
         pend_clr[armed_r] = 1'b1;
      end
      if ((data_wr && armed_r == jlh_pkg::SRC_TX_EMPTY) || transmit_end_of_data_wr) begin
         pend_clr[jlh_pkg::SRC_TX_EMPTY] = 1'b1;
      end
      pend_nxt = (pend_r & ~pend_clr) | pend_set;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pend_r <= '0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // Remembers which data source a vector read armed
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         armed_r <= jlh_pkg::SRC_NONE;
      end else if (vec_rd) begin
         armed_r <= needs_data(vec_src) ? vec_src : jlh_pkg::SRC_NONE;
      end else if (data_rd || data_wr) begin
         armed_r <= jlh_pkg::SRC_NONE;
      end
   end

   // Receive shadow; a new byte overwrites an unread one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_shadow_r <= jlh_pkg::DATA_RESET;
      end else if (link_evt.rx_byte || link_evt.rx_ifr) begin
         rx_shadow_r <= link_evt.rx_data;
      end
   end

   // Transmit shadow, emptied when the engine takes it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_shadow_r <= jlh_pkg::DATA_RESET;
         tx_full_r <= 1'b0;
      end else if (data_wr) begin
         tx_shadow_r <= s_axi_wdata[7:0];
         tx_full_r <= 1'b1;
      end else if (link_evt.tx_take || link_evt.arb_loss) begin
         tx_full_r <= 1'b0;
      end
   end

   // Engine commands
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_ctl <= '0;
      end else begin
         tx_ctl.drive_en <= mode_r == jlh_pkg::JLH_RUN;
         tx_ctl.tx_avail <= tx_full_r && !data_wr;
         tx_ctl.tx_data <= tx_shadow_r;
         tx_ctl.tx_last <= transmit_end_of_data_r;
         // Engine sends two ones then stops on this pulse
         tx_ctl.underrun <= link_evt.tx_byte_done && !tx_full_r &&
            !transmit_end_of_data_r;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         eof_seen_r <= 1'b0;
      end else if (link_evt.eof) begin
         eof_seen_r <= 1'b1;
      end else if (rx_busy) begin
         eof_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_q_r <= 1'b0;
      end else begin
         bus_q_r <= bus_active;
      end
   end

   // Low-power mode sequencer
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= jlh_pkg::JLH_RUN;
         stop_by_wait_r <= 1'b0;
         stop_in_rx_r <= 1'b0;
         stab_r <= '0;
      end else begin
         unique case (mode_r)
            jlh_pkg::JLH_RUN: begin
               if (stop_cmd || (wait_cmd && wcm_r)) begin
                  mode_r <= jlh_pkg::JLH_STOP;
                  stop_by_wait_r <= !stop_cmd && eof_seen_r;
                  stop_in_rx_r <= rx_busy;
               end else if (wait_cmd) begin
                  mode_r <= jlh_pkg::JLH_WAIT;
               end
            end
            jlh_pkg::JLH_WAIT: begin
               if (msg_ok) begin
                  mode_r <= jlh_pkg::JLH_RUN;
               end
            end
            jlh_pkg::JLH_STOP: begin
               if (rise || (stop_in_rx_r && edge_seen)) begin
                  mode_r <= jlh_pkg::JLH_RESTART;
                  stab_r <= SW'(STAB_CYCLES);
               end
            end
            jlh_pkg::JLH_RESTART: begin
               if (stab_r <= SW'(1)) begin
                  mode_r <= jlh_pkg::JLH_RUN;
               end
               stab_r <= stab_r - SW'(1);
            end
         endcase
      end
   end

   // CPU-facing outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
         nmi_req <= 1'b0;
         clk_run <= 1'b1;
         rx_trust <= 1'b1;
      end else begin
         irq <= ie_r && (pend_nxt != '0);
         nmi_req <= mode_r == jlh_pkg::JLH_STOP && (rise ||
            (stop_in_rx_r && edge_seen));
         clk_run <= mode_r == jlh_pkg::JLH_RUN ||
            mode_r == jlh_pkg::JLH_WAIT;
         if (mode_r == jlh_pkg::JLH_STOP) begin
            rx_trust <= stop_by_wait_r && !stop_in_rx_r;
         end else if (mode_r == jlh_pkg::JLH_RUN) begin
            rx_trust <= 1'b1;
         end
      end
   end
endmodule

// [design/jlh_pkg.sv]
// Package: register map, source codes, carriers and timing for the host port
package jlh_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_VECTOR = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_CTRL1 = 8'h08;
   localparam logic [7:0] ADDR_CTRL2 = 8'h0C;
   localparam logic [7:0] ADDR_POWER = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // Control field positions
   localparam int CTRL1_IE_BIT = 0;
   localparam int CTRL1_WCM_BIT = 1;
   localparam int CTRL2_TRANSMIT_END_OF_DATA_BIT = 0;
   localparam int POWER_WAIT_BIT = 0;
   localparam int POWER_STOP_BIT = 1;
   // Reset values
   localparam logic [1:0] CTRL1_RESET = 2'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Source indices, priority rises with index; vector = index * 4
   localparam logic [3:0] SRC_NONE = 4'h0;
   localparam logic [3:0] SRC_EOF = 4'h1;
   localparam logic [3:0] SRC_RX_IFR = 4'h2;
   localparam logic [3:0] SRC_RX_FULL = 4'h3;
   localparam logic [3:0] SRC_TX_EMPTY = 4'h4;
   localparam logic [3:0] SRC_ARB_LOSS = 4'h5;
   localparam logic [3:0] SRC_CRC = 4'h6;
   localparam logic [3:0] SRC_BAD_SYM = 4'h7;
   localparam logic [3:0] SRC_WAKE = 4'h8;
   localparam int NUM_SRC = 8;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Clock restart time after stop-mode wake
   localparam int CLK_PERIOD_NS = 10;
   localparam int STAB_TIME_NS = 1000;
   localparam int STAB_CYC = (STAB_TIME_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      JLH_RUN,
      JLH_WAIT,
      JLH_STOP,
      JLH_RESTART
   } jlh_mode_t;

   // Events from the frame engine, each flag a one-cycle pulse, plus the received byte
   typedef struct packed {
      logic eof;
      logic rx_ifr;
      logic rx_byte;
      logic arb_loss;
      logic crc_err;
      logic bad_sym;
      logic tx_first_bit;
      logic tx_byte_done;
      logic tx_take;
      logic [7:0] rx_data;
   } jlh_link_evt_t;

   // Commands to the frame engine
   typedef struct packed {
      logic drive_en;
      logic tx_avail;
      logic tx_last;
      logic underrun;
      logic [7:0] tx_data;
   } jlh_tx_ctl_t;
endpackage

// [dv/jlh_engine_model.sv]
// Frame engine model: transmit shifter timing plus bench-driven events
`timescale 1ns/1ns
module jlh_engine_model #(
   parameter int BYTE_CYC = 20
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Bench events
   input wire logic [8:0] pulse,
   input wire logic [7:0] rx_val,
   // Host port side
   input wire jlh_pkg::jlh_tx_ctl_t tx_ctl,
   output jlh_pkg::jlh_link_evt_t link_evt
);
   logic [7:0] cnt_r;
   logic [2:0] tx_r;
   logic [7:0] last_r;
   logic rx_now;
   assign rx_now = pulse[7] || pulse[6];
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 8'h00;
         tx_r <= 3'h0;
         last_r <= 8'h00;
      end else begin
         tx_r <= 3'h0;
         if (rx_now) begin
            last_r <= rx_val;
         end
         if (cnt_r == 8'h00) begin
            if (tx_ctl.tx_avail && tx_ctl.drive_en) begin
               tx_r <= 3'h1;
               cnt_r <= 8'h01;
            end
         end else begin
            cnt_r <= (cnt_r == 8'(BYTE_CYC)) ? 8'h00 : cnt_r + 8'h01;
            if (cnt_r == 8'h02) begin
               tx_r <= 3'h4;
            end
            if (cnt_r == 8'(BYTE_CYC)) begin
               tx_r <= 3'h2;
            end
         end
      end
   end
   // Data lines show an inverted copy when no byte is offered
   assign link_evt = {pulse[8:3], pulse[2:0] | tx_r,
      rx_now ? rx_val : ~last_r};
endmodule

// [dv/jlh_host_port_sva.sv]
// Checker: bus handshakes, vector codes, transmit and wake relations
`timescale 1ns/1ns
module jlh_host_port_sva #(
   parameter int STAB_CYCLES = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link and CPU side
   input wire jlh_pkg::jlh_link_evt_t link_evt,
   input wire jlh_pkg::jlh_tx_ctl_t tx_ctl,
   input wire logic nmi_req,
   input wire logic clk_run
);
   // Longest wait for clocks after a stop-mode wake
   localparam int WAKE_MAX = STAB_CYCLES + 1;
   logic rd_vec_r;
   // Marks a pending answer as a vector read
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_vec_r <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
         rd_vec_r <= (s_axi_araddr == jlh_pkg::ADDR_VECTOR);
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_wr_ans;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
         |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_rd_ans;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
         |=> s_axi_arready && s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == jlh_pkg::RESP_SLVERR
         |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error data set");
   property p_vec_code;
      s_axi_rvalid && rd_vec_r
         |-> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata <= 32'h20;
   endproperty
   a_vec_code: assert property (p_vec_code) else $error("bad vector");
   property p_tx_take;
      link_evt.tx_take ##1 !s_axi_awready |=> !tx_ctl.tx_avail;
   endproperty
   a_tx_take: assert property (p_tx_take) else $error("shadow still full");
   property p_underrun;
      link_evt.tx_byte_done && !tx_ctl.tx_avail && !tx_ctl.tx_last
         && !s_axi_awready |=> tx_ctl.underrun;
   endproperty
   a_underrun: assert property (p_underrun) else $error("no underrun");
   property p_under_cause;
      tx_ctl.underrun |-> $past(link_evt.tx_byte_done);
   endproperty
   a_under_cause: assert property (p_under_cause) else $error("stray underrun");
   property p_low_drive;
      !clk_run |-> !tx_ctl.drive_en;
   endproperty
   a_low_drive: assert property (p_low_drive) else $error("drives in stop");
   property p_nmi_wake;
      nmi_req |-> !$past(clk_run) ##1 !clk_run ##[1:WAKE_MAX] clk_run;
   endproperty
   a_nmi_wake: assert property (p_nmi_wake) else $error("bad wake");
endmodule

bind jlh_host_port jlh_host_port_sva #(.STAB_CYCLES(STAB_CYCLES))
   i_jlh_host_port_sva (.core_clk(core_clk), .rstn(rstn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .link_evt(link_evt), .tx_ctl(tx_ctl), .nmi_req(nmi_req),
   .clk_run(clk_run));

// [dv/jlh_host_port_tb.sv]
// Testbench: registers, vector priority, data buffer and low power
`timescale 1ns/1ns
module jlh_host_port_tb;
   localparam logic [7:0] A_VEC = jlh_pkg::ADDR_VECTOR;
   localparam logic [7:0] A_DAT = jlh_pkg::ADDR_DATA;
   localparam logic [7:0] A_C1 = jlh_pkg::ADDR_CTRL1;
   localparam logic [7:0] A_C2 = jlh_pkg::ADDR_CTRL2;
   localparam logic [7:0] A_PWR = jlh_pkg::ADDR_POWER;
   localparam logic [1:0] OK = jlh_pkg::RESP_OKAY;
   localparam logic [1:0] ER = jlh_pkg::RESP_SLVERR;
   logic core_clk = 1'b0, rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_val = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, nmi_req, clk_run, rx_trust;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic rx_busy = 1'b0, bus_active = 1'b0;
   logic [8:0] pulse = 9'h0;
   jlh_pkg::jlh_link_evt_t link_evt;
   jlh_pkg::jlh_tx_ctl_t tx_ctl;
   int err_total = 0, cmp_count = 0, nmi_cnt = 0, und_cnt = 0;
   always #5 core_clk = ~core_clk;
   jlh_host_port #(.STAB_CYCLES(4)) i_jlh_host_port (.core_clk(core_clk),
      .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .link_evt(link_evt), .rx_busy(rx_busy), .bus_active(bus_active),
      .tx_ctl(tx_ctl), .irq(irq), .nmi_req(nmi_req), .clk_run(clk_run),
      .rx_trust(rx_trust));
   jlh_engine_model i_jlh_engine_model (.core_clk(core_clk), .rstn(rstn),
      .pulse(pulse), .rx_val(rx_val), .tx_ctl(tx_ctl), .link_evt(link_evt));
   always @(negedge core_clk) begin
      if (nmi_req === 1'b1) nmi_cnt++;
      if (tx_ctl.underrun === 1'b1) und_cnt++;
   end
   task stop_test;
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end
         while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) err_total++;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end
         while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) err_total++;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task ev(input logic [8:0] p, input logic [7:0] d);
      @(posedge core_clk);
      pulse <= p;
      rx_val <= d;
      @(posedge core_clk);
      pulse <= 9'h0;
      @(negedge core_clk);
   endtask
   // Waits on irq, clk_run, nmi count or underrun count
   task wt(input int sel, input int w);
      int n;
      n = 0;
      while (!((sel == 0 && irq === 1'b1) || (sel == 1 && clk_run === 1'b1)
         || (sel == 2 && nmi_cnt == w) || (sel == 3 && und_cnt == w))
         && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 100) err_total++;
   endtask
   task t_regs;
      rd(A_VEC, 32'h0, OK);
      rd(A_DAT, {24'h0, jlh_pkg::DATA_RESET}, OK);
      rd(A_C1, {30'h0, jlh_pkg::CTRL1_RESET}, OK);
      rd(A_PWR, 32'h0, OK);
      rd(jlh_pkg::ADDR_STATUS, 32'h0, OK);
      rd(8'h40, 32'h0, ER);
      wr(A_VEC, 32'h0, ER);
   endtask
   task t_prio;
      logic [31:0] pv [5] = '{32'h1C, 32'h18, 32'h14, 32'h04, 32'h00};
      ev(9'h138, 8'h00);
      for (int i = 0; i < 5; i++) rd(A_VEC, pv[i], OK);
   endtask
   task t_rx;
      wr(A_C1, 32'h1, OK);
      ev(9'h040, 8'hA5);
      @(negedge core_clk);
      chk({31'h0, irq}, 32'h1);
      rd(A_VEC, 32'h0C, OK);
      rd(A_VEC, 32'h0C, OK);
      rd(A_DAT, 32'hA5, OK);
      rd(A_VEC, 32'h00, OK);
      ev(9'h040, 8'h11);
      ev(9'h040, 8'h22);
      rd(A_VEC, 32'h0C, OK);
      rd(A_DAT, 32'h22, OK);
      ev(9'h080, 8'h66);
      rd(A_VEC, 32'h08, OK);
      rd(A_DAT, 32'h66, OK);
      rd(A_VEC, 32'h00, OK);
   endtask
   task t_tx;
      wr(A_DAT, 32'h3C, OK);
      @(negedge core_clk);
      chk({24'h0, tx_ctl.tx_data}, 32'h3C);
      wt(0, 0);
      rd(A_VEC, 32'h10, OK);
      wr(A_DAT, 32'h5A, OK);
      rd(A_VEC, 32'h00, OK);
      wt(0, 0);
      rd(A_VEC, 32'h10, OK);
      wt(3, 1);
      chk(und_cnt, 32'h1);
      wr(A_C2, 32'h1, OK);
      @(negedge core_clk);
      chk({31'h0, tx_ctl.tx_last}, 32'h1);
      rd(A_VEC, 32'h00, OK);
      ev(9'h100, 8'h00);
      rd(A_VEC, 32'h04, OK);
   endtask
   task t_wait;
      wr(A_PWR, 32'h1, OK);
      @(negedge core_clk);
      chk({30'h0, tx_ctl.drive_en, clk_run}, 32'h1);
      ev(9'h100, 8'h00);
      @(negedge core_clk);
      chk({30'h0, irq, tx_ctl.drive_en}, 32'h3);
      rd(A_VEC, 32'h20, OK);
      rd(A_VEC, 32'h04, OK);
   endtask
   task t_stop;
      ev(9'h100, 8'h00);
      rd(A_VEC, 32'h04, OK);
      wr(A_C1, 32'h3, OK);
      wr(A_PWR, 32'h1, OK);
      @(negedge core_clk);
      chk({30'h0, clk_run, rx_trust}, 32'h1);
      @(posedge core_clk);
      bus_active <= 1'b1;
      wt(2, 1);
      chk(nmi_cnt, 32'h1);
      wt(1, 0);
      rd(A_VEC, 32'h20, OK);
      rx_busy <= 1'b1;
      wr(A_PWR, 32'h2, OK);
      @(negedge core_clk);
      chk({30'h0, clk_run, rx_trust}, 32'h0);
      // Falling edge wakes only because stop began inside a frame
      @(posedge core_clk);
      bus_active <= 1'b0;
      wt(2, 2);
      chk(nmi_cnt, 32'h2);
      wt(1, 0);
      rd(A_VEC, 32'h20, OK);
      rx_busy <= 1'b0;
   endtask
   initial begin
      #100000;
      err_total++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_regs;
      t_prio;
      t_rx;
      t_tx;
      t_wait;
      t_stop;
      stop_test;
   end
endmodule
